// [logic/ee_prot_ctrl.v]
/*
 * Serial EEPROM command, protection and page program logic, plus its data FIFO.
 * Assumes the link pins are asynchronous to CORE_CLK and SCK is at most a
 * fraction of the core rate (bench: 400 ns SCK against 50 ns core clock).
 */
`timescale 1ns/1ps
`include "ee_prot_map.vh"

// ****************************************************************
// Data FIFO
// ****************************************************************
module ee_fifo #(
    parameter WIDTH = 13,
    parameter DEPTH = 8
) (
    // Clock and reset
    input  wire             CORE_CLK,
    input  wire             RSTN,
    // Fill side
    input  wire             IN_VALID,
    input  wire [WIDTH-1:0] IN_DATA,
    output wire             IN_READY,
    // Drain side
    output wire             OUT_VALID,
    output wire [WIDTH-1:0] OUT_DATA,
    input  wire             OUT_READY,
    output wire             EMPTY
);
    localparam AW = (DEPTH <= 2) ? 1 : $clog2(DEPTH);

    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    // Honest full and empty from the fill count
    assign IN_READY  = (count != DEPTH[AW:0]);
    assign OUT_VALID = (count != {(AW+1){1'b0}});
    assign EMPTY     = ~OUT_VALID;
    assign OUT_DATA  = store[rd_ptr];
    assign push      = IN_VALID & IN_READY;
    assign pop       = OUT_VALID & OUT_READY;

    // Pointers and count
    always @(posedge CORE_CLK) begin
        if (!RSTN) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            if (push & ~pop)
                count <= count + 1'b1;
            else if (pop & ~push)
                count <= count - 1'b1;
        end
    end

    // Storage
    always @(posedge CORE_CLK) begin
        if (push)
            store[wr_ptr] <= IN_DATA;
    end
endmodule // ee_fifo

module ee_prot_ctrl #(
    parameter [23:0] P_WRITE_CYCLES = `EE_WRITE_CYCLES
) (
    // Clock and reset
    input  wire CORE_CLK,
    input  wire RSTN,
    // Serial link
    input  wire SCK,
    input  wire CS_N,
    input  wire SI,
    output wire SO,
    output wire SO_OE,
    // Control pins
    input  wire HOLD_N,
    input  wire WP_N,
    // Status view
    output wire BUSY
);
    localparam ST_IDLE  = 3'b001;
    localparam ST_DRAIN = 3'b010;
    localparam ST_PROG  = 3'b100;
    localparam CMD_NONE = 3'h0;
    localparam CMD_STAT = 3'h1;
    localparam CMD_PAGE = 3'h2;
    localparam CMD_READ = 3'h3;
    localparam CMD_FETCH = 3'h4;

    // ****************************************************************
    // Pin synchronisers and edge finders
    // ****************************************************************
    reg  [3:0] sync1;
    reg  [3:0] sync2;
    reg  [3:0] sync3;
    reg        si_s;
    reg        wp_s;
    reg        si_1;
    reg        wp_1;
    wire       sck_s   = sync2[0];
    wire       cs_n_s  = sync2[1];
    wire       hold_s  = sync2[2];
    wire       sck_rise = sync2[0] & ~sync3[0];
    wire       sck_fall = ~sync2[0] & sync3[0];
    wire       cs_rise  = sync2[1] & ~sync3[1];
    wire       hold_fall = ~sync2[2] & sync3[2];
    wire       hold_rise = sync2[2] & ~sync3[2];

    // Two flops per pin, third stage only for edges
    always @(posedge CORE_CLK) begin
        if (!RSTN) begin
            sync1 <= 4'h6; // Idle levels: SCK low, CS_N and HOLD_N high
            sync2 <= 4'h6;
            sync3 <= 4'h6;
            si_1  <= 1'b0;
            si_s  <= 1'b0;
            wp_1  <= 1'b0;
            wp_s  <= 1'b0;
        end else begin
            sync1 <= {1'b0, HOLD_N, CS_N, SCK};
            sync2 <= sync1;
            sync3 <= sync2;
            si_1  <= SI;
            si_s  <= si_1;
            wp_1  <= WP_N;
            wp_s  <= wp_1;
        end
    end

    // ****************************************************************
    // State
    // ****************************************************************
    reg [7:0]  mem [0:`EE_MEM_WORDS-1];
    reg [7:0]  page_buf [0:`EE_PAGE_BYTES-1];
    reg [31:0] page_valid;
    reg [2:0]  state;
    reg        busy;
    reg        latch;
    reg [1:0]  prot;
    reg        lock;
    reg        paused;
    reg [2:0]  bit_cnt;
    reg [2:0]  byte_cnt;
    reg [7:0]  shift_in;
    reg [2:0]  cmd;
    reg [11:0] addr;
    reg [4:0]  col;
    reg [7:0]  stat_new;
    reg        out_active;
    reg [7:0]  out_sr;
    reg [2:0]  out_cnt;
    reg        so_bit;
    reg        so_on;
    reg        prog_page;
    reg [23:0] prog_cnt;
    reg [5:0]  prog_idx;
    wire [7:0] status = {lock, 3'h0, prot, latch, busy};
    wire [7:0] byte_in = {shift_in[6:0], si_s};
    wire       active = ~cs_n_s & ~paused;
    wire       byte_done = active & sck_rise & (bit_cnt == 3'h7);
    wire       fifo_in_ready;
    wire       fifo_out_valid;
    wire [12:0] fifo_out;
    wire       fifo_empty;
    wire       data_push = byte_done & (cmd == CMD_PAGE) & (byte_cnt >= 3'h3);
    wire       page_locked;

    assign BUSY  = busy;
    assign SO    = so_bit;
    assign SO_OE = active & so_on;

    // Page under the address is protected by the current level
    assign page_locked = (prot == 2'h3) |
                         ((prot == 2'h2) & (addr >= `EE_PROT_HALF)) |
                         ((prot == 2'h1) & (addr >= `EE_PROT_QUARTER));

    // Column and data bytes go through the FIFO; drain stalls while programming
    ee_fifo #(.WIDTH(`EE_FIFO_WIDTH), .DEPTH(`EE_FIFO_DEPTH)) u_fifo (
        .CORE_CLK  (CORE_CLK),
        .RSTN      (RSTN),
        .IN_VALID  (data_push),
        .IN_DATA   ({col, byte_in}),
        .IN_READY  (fifo_in_ready),
        .OUT_VALID (fifo_out_valid),
        .OUT_DATA  (fifo_out),
        .OUT_READY (state != ST_PROG),
        .EMPTY     (fifo_empty)
    );

    // ****************************************************************
    // Page buffer entries
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < `EE_PAGE_BYTES; g = g + 1) begin : g_page
            // Latest byte for a column overwrites earlier ones
            always @(posedge CORE_CLK) begin
                if (!RSTN) begin
                    page_valid[g] <= 1'b0;
                    page_buf[g]   <= 8'h00;
                end else if ((state == ST_PROG) & (prog_cnt == P_WRITE_CYCLES)) begin
                    page_valid[g] <= 1'b0;
                end else if (active & (cmd == CMD_NONE) & (bit_cnt == 3'h0) & (byte_cnt == 3'h0) &
                             (state == ST_IDLE)) begin
                    page_valid[g] <= 1'b0;
                end else if (fifo_out_valid & (state != ST_PROG) & (fifo_out[12:8] == g)) begin
                    page_valid[g] <= 1'b1;
                    page_buf[g]   <= fifo_out[7:0];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Serial command decoder
    // ****************************************************************
    always @(posedge CORE_CLK) begin
        if (!RSTN) begin
            paused     <= 1'b0;
            bit_cnt    <= 3'h0;
            byte_cnt   <= 3'h0;
            shift_in   <= 8'h00;
            cmd        <= CMD_NONE;
            addr       <= 12'h000;
            col        <= 5'h00;
            stat_new   <= 8'h00;
            out_active <= 1'b0;
            out_sr     <= 8'h00;
            out_cnt    <= 3'h0;
            so_bit     <= 1'b0;
            so_on      <= 1'b0;
        end else if (cs_n_s) begin
            // Deselect ends pause and resets the sequence
            paused     <= 1'b0;
            bit_cnt    <= 3'h0;
            byte_cnt   <= 3'h0;
            cmd        <= CMD_NONE;
            out_active <= 1'b0;
            out_cnt    <= 3'h0;
            so_on      <= 1'b0;
        end else begin
            // Pause on hold fall with SCK low, resume on hold rise
            if (hold_fall & ~sck_s)
                paused <= 1'b1;
            else if (hold_rise)
                paused <= 1'b0;
            if (active & sck_rise) begin
                shift_in <= byte_in;
                bit_cnt  <= bit_cnt + 3'h1;
            end
            if (byte_done) begin
                if (byte_cnt != 3'h7)
                    byte_cnt <= byte_cnt + 3'h1;
                if (byte_cnt == 3'h0) begin
                    // Busy accepts status fetch only
                    if (byte_in == `EE_OP_STATUS_FETCH) begin
                        cmd        <= CMD_FETCH;
                        out_active <= 1'b1;
                        out_sr     <= status;
                    end else if (busy)
                        cmd <= CMD_NONE;
                    else if (byte_in == `EE_OP_STATUS_PROGRAM)
                        cmd <= CMD_STAT;
                    else if (byte_in == `EE_OP_PAGE_PROGRAM)
                        cmd <= CMD_PAGE;
                    else if (byte_in == `EE_OP_READ)
                        cmd <= CMD_READ;
                    else
                        cmd <= CMD_NONE;
                end else if (byte_cnt == 3'h1) begin
                    addr[11:8] <= byte_in[3:0];
                    stat_new   <= byte_in;
                end else if (byte_cnt == 3'h2) begin
                    addr[7:0] <= byte_in;
                    col       <= byte_in[4:0];
                    if (cmd == CMD_READ) begin
                        out_active <= 1'b1;
                        out_sr     <= mem[{addr[11:8], byte_in}];
                        addr       <= {addr[11:8], byte_in} + 12'h001;
                    end
                end else if (data_push & fifo_in_ready) begin
                    col <= col + 5'h01;
                end
            end
            // Output bit 7 first, reload every eighth falling edge
            if (active & sck_fall & out_active) begin
                so_bit  <= out_sr[~out_cnt];
                so_on   <= 1'b1; // Drive only once the first bit stands
                out_cnt <= out_cnt + 3'h1;
                if (out_cnt == 3'h7) begin
                    if (cmd == CMD_FETCH)
                        out_sr <= status;
                    else begin
                        out_sr <= mem[addr];
                        addr   <= addr + 12'h001;
                    end
                end
            end
        end
    end

    // ****************************************************************
    // Programming sequencer and status register
    // ****************************************************************
    always @(posedge CORE_CLK) begin
        if (!RSTN) begin
            state     <= ST_IDLE;
            busy      <= 1'b0;
            latch     <= 1'b0;
            prot      <= `EE_RST_PROT;
            lock      <= `EE_RST_LOCK;
            prog_page <= 1'b0;
            prog_cnt  <= 24'h00_0000;
            prog_idx  <= 6'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    // Latch commands act on their completed opcode byte
                    if (byte_done & (byte_cnt == 3'h0) & ~busy) begin
                        if (byte_in == `EE_OP_SET_LATCH)
                            latch <= 1'b1;
                        else if (byte_in == `EE_OP_CLEAR_LATCH)
                            latch <= 1'b0;
                    end
                    // Commit only on a whole-byte deselect with the latch set
                    if (cs_rise & (bit_cnt == 3'h0) & latch) begin
                        if ((cmd == CMD_PAGE) & (byte_cnt >= 3'h4) & ~page_locked) begin
                            prog_page <= 1'b1;
                            state     <= ST_DRAIN;
                        end else if ((cmd == CMD_STAT) & (byte_cnt == 3'h2) &
                                     (~lock | wp_s)) begin
                            prog_page <= 1'b0;
                            state     <= ST_DRAIN;
                        end
                    end
                end
                ST_DRAIN: begin
                    // Let the last data bytes reach the page buffer
                    if (fifo_empty) begin
                        busy     <= 1'b1;
                        prog_cnt <= 24'h00_0000;
                        prog_idx <= 6'h00;
                        state    <= ST_PROG;
                    end
                end
                ST_PROG: begin
                    // Fixed busy time, array written in the first cycles
                    prog_cnt <= prog_cnt + 24'h00_0001;
                    if (prog_idx != 6'h20)
                        prog_idx <= prog_idx + 6'h01;
                    if (~prog_page & (prog_cnt == 24'h00_0000)) begin
                        prot <= stat_new[`EE_ST_PROT_HIGH:`EE_ST_PROT_LOW];
                        lock <= stat_new[`EE_ST_LOCK];
                    end
                    if (prog_cnt == P_WRITE_CYCLES) begin
                        busy  <= 1'b0;
                        latch <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Array write, one page column per cycle
    always @(posedge CORE_CLK) begin
        if ((state == ST_PROG) & prog_page & ~prog_idx[5] & page_valid[prog_idx[4:0]])
            mem[{addr[11:5], prog_idx[4:0]}] <= page_buf[prog_idx[4:0]];
    end
endmodule // ee_prot_ctrl

// [logic/ee_prot_map.vh]
/*
 * Constants of the serial EEPROM command and protection block:
 * opcodes, status bit positions, protect ranges, page and FIFO shape, timing.
 * Assumes inclusion by ee_prot_ctrl.v only; definitions only.
 */
`ifndef EE_PROT_MAP_VH
`define EE_PROT_MAP_VH

// ****************************************************************
// Opcodes
// ****************************************************************
`define EE_OP_STATUS_PROGRAM 8'h01
`define EE_OP_PAGE_PROGRAM   8'h02
`define EE_OP_READ           8'h03
`define EE_OP_CLEAR_LATCH    8'h04
`define EE_OP_STATUS_FETCH   8'h05
`define EE_OP_SET_LATCH      8'h06

// ****************************************************************
// Status register layout and reset values
// ****************************************************************
`define EE_ST_BUSY       0
`define EE_ST_LATCH      1
`define EE_ST_PROT_LOW   2
`define EE_ST_PROT_HIGH  3
`define EE_ST_LOCK       7
`define EE_RST_PROT      2'h0
`define EE_RST_LOCK      1'h0

// ****************************************************************
// Protected range starts
// ****************************************************************
`define EE_PROT_QUARTER  12'h0C00
`define EE_PROT_HALF     12'h0800

// ****************************************************************
// Array, page and FIFO shape
// ****************************************************************
`define EE_ADDR_W        12
`define EE_MEM_WORDS     4096
`define EE_PAGE_BYTES    32
`define EE_FIFO_DEPTH    8
`define EE_FIFO_WIDTH    13

// ****************************************************************
// Timing: longest program time, core clock period, cycle count
// ****************************************************************
`define EE_WRITE_TIME_NS 5000000
`define EE_CLK_PERIOD_NS 50
`define EE_WRITE_CYCLES  24'h01_86A0 // 5 ms of 50 ns cycles, sized for the counter

`endif

// [verif/ee_host_model.sv]
/* Serial host model: mode 0 frames, pause pin and write-protect pin.
   Assumes a 50 ns clock; SCK half period is four clocks (400 ns SCK). */
`timescale 1ns/1ps
module ee_host_model (
    // Core clock
    input  wire logic clk,
    // Link pins
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    input  wire logic so,
    input  wire logic so_oe,
    // Control pins
    output logic      hold_n,
    output logic      wp_n
);
    // Idle levels; chip select high from power-up
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
        wp_n = 1'b1;
    end
    // Data line carries a changing pattern while deselected
    always @(posedge clk) begin
        if (cs_n) si <= ~si;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One selected frame, MSB first, with an optional pause before bit hold_at
    task automatic frame(input logic [7:0] t[$], input int nbits, input int hold_at,
                         output logic [7:0] r[$], output logic oe);
        logic [7:0] sh;
        r = {};
        oe = 1'b1;
        sh = 8'h00;
        cs_n <= 1'b0;
        tick(4);
        for (int b = 0; b < nbits; b++) begin
            if (b == hold_at) begin
                tick(4);
                hold_n <= 1'b0;
                tick(8);
                oe = so_oe;
                // Five clocks: a missed pause would rotate the status byte
                repeat (5) begin
                    si <= ~si;
                    sck <= 1'b1;
                    tick(4);
                    sck <= 1'b0;
                    tick(4);
                end
                hold_n <= 1'b1;
                tick(8);
            end
            si <= t[b / 8][7 - b % 8];
            tick(4);
            sck <= 1'b1;
            tick(4);
            sh = {sh[6:0], so_oe ? so : 1'b1}; // Released line reads as pulled high
            sck <= 1'b0;
            if (b % 8 == 7) r.push_back(sh);
        end
        tick(4);
        cs_n <= 1'b1;
        tick(8);
    endtask
endmodule // ee_host_model

// [verif/ee_prot_ctrl_sva.sv]
/* Pin checker of the EEPROM command block, bound into ee_prot_ctrl.
   Assumes the 50 ns core clock and a shortened P_WRITE_CYCLES. */
`timescale 1ns/1ps
module ee_prot_ctrl_sva #(
    parameter [23:0] P_WRITE_CYCLES = 24'h01_86a0
) (
    // Clock and reset
    input wire CORE_CLK,
    input wire RSTN,
    // Link pins
    input wire SCK,
    input wire CS_N,
    input wire SI,
    input wire SO,
    input wire SO_OE,
    input wire HOLD_N,
    input wire WP_N,
    // Status view
    input wire BUSY
);
    logic [23:0] bcnt;
    // Cycles seen with BUSY high
    always @(posedge CORE_CLK) begin
        if (!RSTN || !BUSY) bcnt <= 24'h00_0000;
        else bcnt <= bcnt + 24'h00_0001;
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    // ********************
    // Properties
    // ********************
    a_oe_deselect: assert property (CS_N [*6] |-> !SO_OE)
        else $error("output driven while deselected");
    a_oe_paused: assert property (!HOLD_N [*6] |-> !SO_OE)
        else $error("output driven while paused");
    a_oe_rise_low: assert property ($rose(SO_OE) |-> !CS_N && !SCK)
        else $error("output enabled outside a low clock phase");
    a_so_after_fall: assert property (SO_OE && $past(SO_OE) && $changed(SO) |-> !$past(SCK))
        else $error("output changed outside low clock phase");
    a_busy_cause: assert property ($rose(BUSY) |-> CS_N && $past(CS_N))
        else $error("busy began while selected");
    a_busy_hold: assert property ($rose(BUSY) |-> BUSY [*8])
        else $error("busy dropped early");
    a_busy_length: assert property ($fell(BUSY) |-> bcnt == P_WRITE_CYCLES + 24'h00_0001)
        else $error("busy length wrong");
    a_busy_bound: assert property (bcnt <= P_WRITE_CYCLES + 24'h00_0001)
        else $error("busy too long");
    c_busy_end: cover property ($fell(BUSY));
    c_output_on: cover property ($rose(SO_OE));
    c_pause_clocked: cover property (!HOLD_N && !CS_N && SCK);
endmodule // ee_prot_ctrl_sva

bind ee_prot_ctrl ee_prot_ctrl_sva #(.P_WRITE_CYCLES(P_WRITE_CYCLES)) u_sva (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
    .SCK(SCK), .CS_N(CS_N), .SI(SI), .SO(SO), .SO_OE(SO_OE), .HOLD_N(HOLD_N), .WP_N(WP_N), .BUSY(BUSY));

// [verif/ee_prot_ctrl_test.sv]
/* Self-checking bench of the EEPROM command and protection block.
   Assumes the host model drives SCK, CS_N, SI, HOLD_N and WP_N; a model here gives expectations. */
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ee_prot_ctrl_test;
    localparam [23:0] WCYC = 24'h00_03e8;
    logic CORE_CLK = 1'b0;
    logic RSTN = 1'b0;
    wire  SCK, CS_N, SI, SO, SO_OE, HOLD_N, WP_N, BUSY;
    int   n_fail = 0;
    int   total_checks = 0;
    int   mem[4096];
    int   prot = 0;
    int   lock = 0;
    int   latch = 0;
    int   a;
    logic [7:0] tx[$];
    logic [7:0] rx[$];
    logic oe;
    // Core clock, 50 ns
    always #25 CORE_CLK = ~CORE_CLK;
    ee_prot_ctrl #(.P_WRITE_CYCLES(WCYC)) dut (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .SCK(SCK), .CS_N(CS_N),
        .SI(SI), .SO(SO), .SO_OE(SO_OE), .HOLD_N(HOLD_N), .WP_N(WP_N), .BUSY(BUSY));
    ee_host_model host (.clk(CORE_CLK), .sck(SCK), .cs_n(CS_N), .si(SI), .so(SO), .so_oe(SO_OE),
        .hold_n(HOLD_N), .wp_n(WP_N));
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Bounded wait for the end of a program cycle
    task wait_idle;
        int n;
        repeat (10) @(posedge CORE_CLK);
        for (n = 0; BUSY !== 1'b0 && n < 2000; n++) @(posedge CORE_CLK);
        if (n >= 2000) begin
            n_fail++;
            conclude();
        end
    endtask
    // Reference model: effect of one finished frame
    task automatic apply(input int nbits);
        int n;
        int top;
        n = nbits / 8;
        top = (prot == 3) ? 0 : (prot == 2) ? 12'h800 : (prot == 1) ? 12'hc00 : 13'h1000;
        if (nbits % 8 != 0) return;
        if (tx[0] == 8'h06) latch = 1;
        if (tx[0] == 8'h04) latch = 0;
        if (tx[0] == 8'h01 && n == 2 && latch == 1 && !(lock == 1 && host.wp_n == 1'b0)) begin
            prot = tx[1][3:2];
            lock = tx[1][7];
            latch = 0;
        end
        if (tx[0] == 8'h02 && n >= 4 && latch == 1 && {tx[1][3:0], tx[2]} < top) begin
            a = {tx[1][3:0], tx[2]};
            for (int k = 3; k < n; k++) mem[{a[11:5], 5'(a[4:0] + k - 3)}] = tx[k];
            latch = 0;
        end
    endtask
    // Mode 0 applies and waits, 1 applies only, 2 neither (sent while busy)
    task automatic cmd(input int nbits, input int mode);
        host.frame(tx, nbits, -1, rx, oe);
        if (mode != 2) apply(nbits);
        if (mode == 0) wait_idle();
    endtask
    task automatic send1(input logic [7:0] op);
        tx = {op};
        cmd(8, 0);
    endtask
    // Page program with a random unused top nibble in the first address byte, and random data
    task automatic page(input int pa, input int cnt, input int extra, input int mode);
        tx = {8'h02, {4'($urandom), 4'(pa >> 8)}, 8'(pa)};
        repeat (cnt + 1) tx.push_back(8'($urandom));
        cmd(8 * (3 + cnt) + extra, mode);
    endtask
    // Status fetch of two bytes with a clocked pause between them
    task automatic chk_status(input logic [7:0] extra);
        logic [7:0] e;
        e = {lock[0], 3'b000, prot[1:0], latch[0], 1'b0} | extra;
        tx = {8'h05, 8'h00, 8'h00};
        host.frame(tx, 24, 16, rx, oe);
        `CHK(rx[1], e)
        `CHK(rx[2], e)
        `CHK(oe, 1'b0)
    endtask
    task automatic chk_mem(input int ra, input int cnt);
        tx = {8'h03, 8'(ra >> 8), 8'(ra)};
        repeat (cnt) tx.push_back(8'h00);
        host.frame(tx, 8 * (3 + cnt), -1, rx, oe);
        for (int k = 0; k < cnt; k++) begin
            if (mem[(ra + k) % 4096] >= 0) `CHK(rx[3 + k], 8'(mem[(ra + k) % 4096]))
        end
    endtask
    // Main sequence
    initial begin
        void'($urandom(32'h0000_b5da));
        foreach (mem[i]) mem[i] = -1;
        repeat (2) @(posedge CORE_CLK);
        RSTN <= 1'b1;
        repeat (8) @(posedge CORE_CLK);
        chk_status(8'h00);
        send1(8'h06);
        chk_status(8'h00);
        send1(8'h04);
        chk_status(8'h00);
        $display("test latch done");
        send1(8'h06);
        page(12'h11e, 40, 0, 0);
        chk_mem(12'h100, 32);
        chk_status(8'h00);
        page(12'h104, 2, 0, 0);
        send1(8'h06);
        page(12'h108, 2, 3, 0);
        chk_status(8'h00);
        chk_mem(12'h100, 12);
        $display("test page done");
        page(12'h120, 2, 0, 1);
        page(12'h121, 1, 0, 2);
        chk_status(8'h03);
        wait_idle();
        chk_mem(12'h120, 2);
        chk_status(8'h00);
        $display("test busy done");
        for (int p = 0; p < 4; p++) begin
            send1(8'h06);
            tx = {8'h01, 8'(p << 2)};
            cmd(16, 0);
            for (int j = 0; j < 3; j++) begin
                send1(8'h06);
                page(12'h040 + ((j > 0) ? 12'h400 * (j + 1) : 0), 2, 0, 0);
                chk_mem(12'h040 + ((j > 0) ? 12'h400 * (j + 1) : 0), 2);
                chk_status(8'h00);
            end
        end
        $display("test protect done");
        send1(8'h06);
        tx = {8'h01, 8'h8c};
        cmd(16, 0);
        @(posedge CORE_CLK) host.wp_n <= 1'b0;
        send1(8'h06);
        tx = {8'h01, 8'h00};
        cmd(16, 0);
        chk_status(8'h00);
        @(posedge CORE_CLK) host.wp_n <= 1'b1;
        tx = {8'h01, 8'h00, 8'h00};
        cmd(24, 0);
        chk_status(8'h00);
        tx = {8'h01, 8'h00};
        cmd(16, 0);
        chk_status(8'h00);
        $display("test lock done");
        conclude();
    end
endmodule // ee_prot_ctrl_test
